// >>> hdl/spsi_pkg.sv
// Behaviour
// - open fence gate drops and blocks servo
// - teach mode ignores the fence gate
// - remote estop drops servo, halts job
// - servo stays off while estop persists
// - protective stop drops servo immediately
// - disagreeing protective channels raise an alarm
// - pendant estop contact passed through, normally closed
// - servo on only on request rising edge
// - playback starts only on start rising edge
// - eight discrete inputs and eight outputs
// - four fast direct inputs
package spsi_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0]  ADDR_GP_OUT   = 8'h10;
  localparam logic [7:0]  ADDR_GP_IN    = 8'h14;
  localparam logic [7:0]  ADDR_DIRECT   = 8'h18;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_TEACH     = 0;  // level, teach mode select
  localparam int CTRL_JOB_STOP  = 1;  // write one: stop running job
  localparam int CTRL_ALM_RESET = 2;  // write one: clear channel alarm
  localparam int CTRL_W         = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int ST_SERVO   = 0;
  localparam int ST_RUNNING = 1;
  localparam int ST_FENCE   = 2;
  localparam int ST_ESTOP   = 3;
  localparam int ST_PSTOP0  = 4;
  localparam int ST_PSTOP1  = 5;
  localparam int ST_ALARM   = 6;
  localparam int ST_PENDANT = 7;
  localparam int ST_W       = 8;

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  localparam int EV_FENCE_TRIP = 0;
  localparam int EV_ESTOP_TRIP = 1;
  localparam int EV_PSTOP_TRIP = 2;
  localparam int EV_CH_ALARM   = 3;
  localparam int EV_SERVO_ON   = 4;
  localparam int EV_JOB_START  = 5;
  localparam int EV_DIRECT0    = 6;
  localparam int EV_W          = 10;
  localparam logic [9:0] IRQ_MASK_RESET = 10'h000;

  // ----------------------------------------------------------------
  // synchronised input vector layout
  // ----------------------------------------------------------------
  localparam int GP_W      = 8;
  localparam int DIRECT_W  = 4;
  localparam int IN_FENCE  = 0;
  localparam int IN_ESTOP  = 1;
  localparam int IN_PSTOP0 = 2;
  localparam int IN_PSTOP1 = 3;
  localparam int IN_SRVREQ = 4;
  localparam int IN_START  = 5;
  localparam int IN_GP0    = 6;
  localparam int IN_DIR0   = 14;
  localparam int IN_W      = 18;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int DISC_TIME_NS   = 100000;
  localparam int DISC_CYCLES    = DISC_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // servo state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPSI_OFF = 3'b001,
    SPSI_ON  = 3'b010,
    SPSI_RUN = 3'b100
  } spsi_state_t;

endpackage

// >>> hdl/spsi_in_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spsi_in_if #(parameter int W = 1);
  logic [W-1:0] sync;
  logic [W-1:0] rise;
  modport sync_mp (output sync);
  modport edge_mp (input sync, output rise);
  modport user_mp (input sync, input rise);
endinterface
`default_nettype wire

// >>> hdl/spsi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module spsi_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // raw pins and synchronised side
  input  wire logic [W-1:0] raw,
  spsi_in_if.sync_mp        sig
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // first stage is read by the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  assign sig.sync = sync_r;
endmodule // spsi_sync
`default_nettype wire

// >>> hdl/spsi_edge.sv
`timescale 1ns/1ps
`default_nettype none
module spsi_edge #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // synchronised levels in, rising pulses out
  spsi_in_if.edge_mp sig
);
  localparam int SETTLE = 2;  // synchroniser depth

  logic [W-1:0] prev_r;
  logic [1:0]   settle_r;

  // prev stays high until the synchroniser shows real pin levels, so a
  // level held through reset gives no edge; a rise that falls inside
  // those first cycles is lost as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r   <= '1;
      settle_r <= '0;
    end else if (settle_r != 2'(SETTLE)) begin
      settle_r <= settle_r + 2'h1;
    end else begin
      prev_r <= sig.sync;
    end
  end

  assign sig.rise = sig.sync & ~prev_r;
endmodule // spsi_edge
`default_nettype wire

// >>> hdl/spsi_interlock.sv
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module spsi_interlock #(
  parameter int GP_W        = spsi_pkg::GP_W,
  parameter int DIRECT_W    = spsi_pkg::DIRECT_W,
  parameter int DISC_CYCLES = spsi_pkg::DISC_CYCLES
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // safety inputs, high = contact closed
  input  wire logic                fence_gate_interlock,
  input  wire logic                remote_estop_input,
  input  wire logic [1:0]          protective_stop_input,
  input  wire logic                pendant_estop_in,
  // external sequencing requests
  input  wire logic                ext_servo_on_req,
  input  wire logic                ext_start_req,
  // general discrete io and direct inputs
  input  wire logic [GP_W-1:0]     general_discrete_in,
  output logic      [GP_W-1:0]     general_discrete_out,
  input  wire logic [DIRECT_W-1:0] direct_in,
  // results
  output logic                     servo_power_en,
  output logic                     job_running,
  output logic                     safety_alarm,
  output logic                     pendant_estop_contact_out,
  output logic                     irq
);

  // ----------------------------------------------------------------
  // input synchronisation and edge detection
  // ----------------------------------------------------------------
  localparam int IW = spsi_pkg::IN_W;

  logic [IW-1:0] raw_in;
  spsi_in_if #(.W(IW)) in_sig ();

  assign raw_in = {direct_in, general_discrete_in, ext_start_req,
                   ext_servo_on_req, protective_stop_input,
                   remote_estop_input, fence_gate_interlock};

  spsi_sync #(.W(IW)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (raw_in),
    .sig     (in_sig.sync_mp)
  );

  spsi_edge #(.W(IW)) u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .sig     (in_sig.edge_mp)
  );

  logic fence_ok;
  logic estop_ok;
  logic pstop0;
  logic pstop1;
  logic srv_rise;
  logic start_rise;
  logic [GP_W-1:0]     gp_in;
  logic [DIRECT_W-1:0] dir_in;
  logic [DIRECT_W-1:0] dir_rise;

  assign fence_ok   = in_sig.sync[spsi_pkg::IN_FENCE];
  assign estop_ok   = in_sig.sync[spsi_pkg::IN_ESTOP];
  assign pstop0     = in_sig.sync[spsi_pkg::IN_PSTOP0];
  assign pstop1     = in_sig.sync[spsi_pkg::IN_PSTOP1];
  assign srv_rise   = in_sig.rise[spsi_pkg::IN_SRVREQ];
  assign start_rise = in_sig.rise[spsi_pkg::IN_START];
  assign gp_in      = in_sig.sync[spsi_pkg::IN_GP0 +: GP_W];
  assign dir_in     = in_sig.sync[spsi_pkg::IN_DIR0 +: DIRECT_W];
  assign dir_rise   = in_sig.rise[spsi_pkg::IN_DIR0 +: DIRECT_W];

  // ----------------------------------------------------------------
  // apb access decode
  // ----------------------------------------------------------------
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        acc_done;
  logic        wr_en;
  logic        rd_hit;
  logic [31:0] rd_val;

  logic [spsi_pkg::CTRL_W-1:0] ctrl_r;
  logic [spsi_pkg::EV_W-1:0]   irq_stat_r;
  logic [spsi_pkg::EV_W-1:0]   irq_mask_r;
  logic [GP_W-1:0]             gp_out_r;
  logic [spsi_pkg::ST_W-1:0]   status;

  // one wait state: pready rises in the second access cycle
  assign acc_done = psel & penable & pready_r;
  assign wr_en    = acc_done & pwrite;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      spsi_pkg::ADDR_CTRL:     rd_val[spsi_pkg::CTRL_W-1:0] = ctrl_r;
      spsi_pkg::ADDR_STATUS:   rd_val[spsi_pkg::ST_W-1:0]   = status;
      spsi_pkg::ADDR_IRQ_STAT: rd_val[spsi_pkg::EV_W-1:0]   = irq_stat_r;
      spsi_pkg::ADDR_IRQ_MASK: rd_val[spsi_pkg::EV_W-1:0]   = irq_mask_r;
      spsi_pkg::ADDR_GP_OUT:   rd_val[GP_W-1:0]             = gp_out_r;
      spsi_pkg::ADDR_GP_IN:    rd_val[GP_W-1:0]             = gp_in;
      spsi_pkg::ADDR_DIRECT:   rd_val[DIRECT_W-1:0]         = dir_in;
      default:                 rd_hit                       = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel & penable & ~pready_r;
      if (psel & penable & ~pready_r) begin
        prdata_r  <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr_r <= ~rd_hit;
      end else begin
        prdata_r  <= 32'h0000_0000;
        pslverr_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control and discrete output registers
  // ----------------------------------------------------------------
  logic teach_mode;
  logic job_stop_wr;
  logic alm_reset_wr;

  assign teach_mode   = ctrl_r[spsi_pkg::CTRL_TEACH];
  assign job_stop_wr  = wr_en & (paddr == spsi_pkg::ADDR_CTRL)
                        & pwdata[spsi_pkg::CTRL_JOB_STOP];
  assign alm_reset_wr = wr_en & (paddr == spsi_pkg::ADDR_CTRL)
                        & pwdata[spsi_pkg::CTRL_ALM_RESET];

  // the two command bits are strobes and never read back as one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= spsi_pkg::CTRL_RESET;
    end else if (wr_en && paddr == spsi_pkg::ADDR_CTRL) begin
      ctrl_r <= {2'b00, pwdata[spsi_pkg::CTRL_TEACH]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_out_r <= '0;
    end else if (wr_en && paddr == spsi_pkg::ADDR_GP_OUT) begin
      gp_out_r <= pwdata[GP_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // protective stop channel discrepancy
  // ----------------------------------------------------------------
  // channels never switch in exactly the same cycle, so a short
  // disagreement window is tolerated before the alarm latches
  localparam int DW = $clog2(DISC_CYCLES + 1);

  logic [DW-1:0] disc_cnt_r;
  logic          alarm_r;
  logic          disc_hit;

  assign disc_hit = (disc_cnt_r == DW'(DISC_CYCLES));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disc_cnt_r <= '0;
    end else if (pstop0 == pstop1) begin
      disc_cnt_r <= '0;
    end else if (!disc_hit) begin
      disc_cnt_r <= disc_cnt_r + DW'(1);
    end
  end

  // alarm is only cleared once both channels agree again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_r <= 1'b0;
    end else if (disc_hit) begin
      alarm_r <= 1'b1;
    end else if (alm_reset_wr && pstop0 == pstop1) begin
      alarm_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // servo power state
  // ----------------------------------------------------------------
  spsi_pkg::spsi_state_t state_r;
  spsi_pkg::spsi_state_t state_nxt;

  logic fence_perm;
  logic pstop_ok;
  logic permit;

  assign fence_perm = fence_ok | teach_mode;
  assign pstop_ok   = pstop0 & pstop1;
  assign permit     = fence_perm & estop_ok & pstop_ok & ~alarm_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      spsi_pkg::SPSI_OFF: begin
        if (permit && srv_rise) begin
          state_nxt = spsi_pkg::SPSI_ON;
        end
      end
      spsi_pkg::SPSI_ON: begin
        if (!permit) begin
          state_nxt = spsi_pkg::SPSI_OFF;
        end else if (start_rise) begin
          state_nxt = spsi_pkg::SPSI_RUN;
        end
      end
      spsi_pkg::SPSI_RUN: begin
        if (!permit) begin
          state_nxt = spsi_pkg::SPSI_OFF;
        end else if (job_stop_wr) begin
          state_nxt = spsi_pkg::SPSI_ON;
        end
      end
      default: state_nxt = spsi_pkg::SPSI_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= spsi_pkg::SPSI_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // enable is a flop fed by the permissive AND, no combinational path
  logic servo_en_r;
  logic running_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_en_r <= 1'b0;
      running_r  <= 1'b0;
    end else begin
      servo_en_r <= permit & (state_nxt != spsi_pkg::SPSI_OFF);
      running_r  <= permit & (state_nxt == spsi_pkg::SPSI_RUN);
    end
  end

  // ----------------------------------------------------------------
  // pendant estop contact
  // ----------------------------------------------------------------
  // single flop only: the real contact path bypasses this logic, so
  // the output shows the opened state while the controller is reset
  logic pendant_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pendant_r <= 1'b0;
    end else begin
      pendant_r <= pendant_estop_in;
    end
  end

  // ----------------------------------------------------------------
  // status and interrupts
  // ----------------------------------------------------------------
  logic                       was_on;
  logic [spsi_pkg::EV_W-1:0]  events;
  logic [spsi_pkg::EV_W-1:0]  w1c;
  logic                       irq_r;

  assign was_on = (state_r != spsi_pkg::SPSI_OFF);

  assign status = {pendant_r, alarm_r, pstop1, pstop0, estop_ok,
                   fence_ok, running_r, servo_en_r};

  always_comb begin
    events = '0;
    events[spsi_pkg::EV_FENCE_TRIP] = was_on & ~fence_perm;
    events[spsi_pkg::EV_ESTOP_TRIP] = was_on & ~estop_ok;
    events[spsi_pkg::EV_PSTOP_TRIP] = was_on & ~pstop_ok;
    events[spsi_pkg::EV_CH_ALARM]   = disc_hit & ~alarm_r;
    events[spsi_pkg::EV_SERVO_ON]   = ~was_on
                                      & (state_nxt == spsi_pkg::SPSI_ON);
    events[spsi_pkg::EV_JOB_START]  = (state_r == spsi_pkg::SPSI_ON)
                                      & (state_nxt == spsi_pkg::SPSI_RUN);
    events[spsi_pkg::EV_DIRECT0 +: DIRECT_W] = dir_rise;
  end

  assign w1c = (wr_en && paddr == spsi_pkg::ADDR_IRQ_STAT)
               ? pwdata[spsi_pkg::EV_W-1:0] : '0;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~w1c) | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= spsi_pkg::IRQ_MASK_RESET;
    end else if (wr_en && paddr == spsi_pkg::ADDR_IRQ_MASK) begin
      irq_mask_r <= pwdata[spsi_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(((irq_stat_r & ~w1c) | events) & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata                    = prdata_r;
  assign pready                    = pready_r;
  assign pslverr                   = pslverr_r;
  assign general_discrete_out      = gp_out_r;
  assign servo_power_en            = servo_en_r;
  assign job_running               = running_r;
  assign safety_alarm              = alarm_r;
  assign pendant_estop_contact_out = pendant_r;
  assign irq                       = irq_r;

endmodule // spsi_interlock
`default_nettype wire

// >>> tb/spsi_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module spsi_far_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench commands
  input  wire logic       pstop_ok,
  input  wire logic       split,
  input  wire logic       start_go,
  input  wire logic       drop,
  // device feedback
  input  wire logic       job_running,
  // lines into the device
  output logic      [1:0] protective_stop_input,
  output logic            ext_start_req
);
  // ----------
  // protective stop relay
  // ----------
  // split breaks the pairing on purpose
  always_ff @(posedge pclk) begin
    protective_stop_input <= split ? 2'b01 : {2{pstop_ok}};
  end

  // ----------
  // start sequencer
  // ----------
  // drop: outside interlocks abandon a refused start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_start_req <= 1'b0;
    end else if (start_go) begin
      ext_start_req <= 1'b1;
    end else if (job_running || drop) begin
      ext_start_req <= 1'b0;
    end
  end
endmodule // spsi_far_model
`default_nettype wire

// >>> tb/spsi_interlock_properties.sv
`timescale 1ns/1ps
`default_nettype none
module spsi_interlock_properties #(
  parameter int DISC_CYCLES = 2000
) (
  // clock, reset and bus handshake
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pready,
  // safety side
  input  wire logic       remote_estop_input,
  input  wire logic [1:0] protective_stop_input,
  input  wire logic       pendant_estop_in,
  input  wire logic       ext_servo_on_req,
  input  wire logic       ext_start_req,
  // results
  input  wire logic       servo_power_en,
  input  wire logic       job_running,
  input  wire logic       safety_alarm,
  input  wire logic       pendant_estop_contact_out,
  input  wire logic       irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------
  // request age and channel disagreement counters
  // ----------
  // levels reset high: a request held through reset is no edge
  logic        srv_prev_r, st_prev_r;
  logic [3:0]  srv_age_r, st_age_r;
  int unsigned disc_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srv_prev_r <= 1'b1;
      st_prev_r  <= 1'b1;
      srv_age_r  <= 4'hF;
      st_age_r   <= 4'hF;
    end else begin
      srv_prev_r <= ext_servo_on_req;
      st_prev_r  <= ext_start_req;
      if (ext_servo_on_req && !srv_prev_r)
        srv_age_r <= 4'h0;
      else if (srv_age_r != 4'hF)
        srv_age_r <= srv_age_r + 4'h1;
      if (ext_start_req && !st_prev_r)
        st_age_r <= 4'h0;
      else if (st_age_r != 4'hF)
        st_age_r <= st_age_r + 4'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      disc_cnt_r <= 0;
    else
      disc_cnt_r <= (^protective_stop_input) ? disc_cnt_r + 1 : 0;
  end

  // ----------
  // assertions
  // ----------
  estop_drop_a: assert property (
    !remote_estop_input |-> ##[1:5] !servo_power_en)
    else $error("servo stayed on after estop opened");
  estop_block_a: assert property (
    !remote_estop_input [*6] |-> !servo_power_en)
    else $error("servo on while estop persists");
  pstop_drop_a: assert property (
    !(&protective_stop_input) |-> ##[1:5] !servo_power_en)
    else $error("servo stayed on after protective stop");
  run_needs_servo_a: assert property (
    job_running |-> servo_power_en)
    else $error("job running without servo power");
  servo_edge_a: assert property (
    $rose(servo_power_en) |-> srv_age_r <= 4'd8)
    else $error("servo on without a request edge");
  start_edge_a: assert property (
    $rose(job_running) |-> st_age_r <= 4'd8)
    else $error("job started without a start edge");
  alarm_latch_a: assert property (
    disc_cnt_r > DISC_CYCLES + 6 |-> safety_alarm)
    else $error("channel disagreement raised no alarm");
  alarm_block_a: assert property (
    safety_alarm |-> !servo_power_en)
    else $error("servo on while channel alarm stands");
  pendant_pass_a: assert property (
    $past(presetn) |-> pendant_estop_contact_out == $past(pendant_estop_in))
    else $error("pendant contact not passed through");
  apb_wait_a: assert property (
    psel && !penable |=> !pready ##1 pready)
    else $error("bus answer not after one wait state");

  servo_on_c: cover property ($rose(servo_power_en));
  job_run_c:  cover property ($rose(job_running));
  alarm_c:    cover property ($rose(safety_alarm));
  irq_c:      cover property ($rose(irq));
endmodule // spsi_interlock_properties

bind spsi_interlock spsi_interlock_properties #(.DISC_CYCLES(DISC_CYCLES))
  i_spsi_interlock_properties (.*);
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DISC = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, serr;
  logic [7:0]  paddr, gp_in, gp_out;
  logic [31:0] pwdata, prdata, rnd, q;
  logic        fence, estop, pend, pend_out, srv_req, start_req;
  logic        pstop_ok, split, start_go, drop;
  logic [1:0]  pstop;
  logic [3:0]  dir_in;
  logic        servo, running, alarm, irq;
  int          fails, num_checks;

  spsi_interlock #(.DISC_CYCLES(DISC)) i_spsi_interlock (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(serr), .fence_gate_interlock(fence),
    .remote_estop_input(estop), .protective_stop_input(pstop),
    .pendant_estop_in(pend), .ext_servo_on_req(srv_req),
    .ext_start_req(start_req), .general_discrete_in(gp_in),
    .general_discrete_out(gp_out), .direct_in(dir_in),
    .servo_power_en(servo), .job_running(running), .safety_alarm(alarm),
    .pendant_estop_contact_out(pend_out), .irq(irq));

  spsi_far_model i_spsi_far_model (
    .pclk(pclk), .presetn(presetn), .pstop_ok(pstop_ok), .split(split),
    .start_go(start_go), .drop(drop), .job_running(running),
    .protective_stop_input(pstop), .ext_start_req(start_req));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk_word(nm, e, q);
  endtask

  task automatic pulse_srv;
    cyc(1);
    srv_req <= 1'b0;
    cyc(3);
    srv_req <= 1'b1;
    cyc(8);
  endtask

  task automatic start_seq;
    drop <= 1'b1;
    cyc(2);
    drop     <= 1'b0;
    start_go <= 1'b1;
    cyc(1);
    start_go <= 1'b0;
    cyc(8);
  endtask

  task automatic test_end(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    cyc(20000);
    fails++;
    $display("[FAIL] watchdog expected done seen hang");
    tally_and_finish;
  end

  initial begin
    fails = 0;
    num_checks = 0;
    rnd = 32'h38FB21E8;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fence, estop, pend, srv_req, pstop_ok} = 5'h1F;
    {split, start_go, drop, gp_in, dir_in} = '0;
    cyc(4);
    presetn <= 1'b1;
    cyc(6);
    chk_bit("servo_power_en", 1'b0, servo);
    rd(spsi_pkg::ADDR_CTRL, 32'h0, "ctrl");
    rd(spsi_pkg::ADDR_IRQ_MASK, 32'h0, "irq_mask");
    rd(spsi_pkg::ADDR_STATUS, 32'h0000_00BC, "status");
    rd(8'h1C, 32'h0, "unmapped");
    chk_bit("pslverr", 1'b1, serr);
    test_end("reset");
    // start held while servo is off, then still held once servo is on
    start_go <= 1'b1;
    cyc(1);
    start_go <= 1'b0;
    cyc(8);
    chk_bit("job_running", 1'b0, running);
    pulse_srv;
    chk_bit("servo_power_en", 1'b1, servo);
    chk_bit("job_running", 1'b0, running);
    start_seq;
    chk_bit("job_running", 1'b1, running);
    chk_bit("ext_start_req", 1'b0, start_req);
    apb(1'b1, spsi_pkg::ADDR_CTRL, 32'h2);
    cyc(4);
    chk_bit("job_running", 1'b0, running);
    chk_bit("servo_power_en", 1'b1, servo);
    test_end("servo_start");
    start_seq;
    estop <= 1'b0;
    cyc(8);
    chk_bit("servo_power_en", 1'b0, servo);
    chk_bit("job_running", 1'b0, running);
    pulse_srv;
    chk_bit("servo_power_en", 1'b0, servo);
    estop <= 1'b1;
    cyc(8);
    chk_bit("servo_power_en", 1'b0, servo);
    pulse_srv;
    chk_bit("servo_power_en", 1'b1, servo);
    test_end("estop");
    fence <= 1'b0;
    cyc(8);
    chk_bit("servo_power_en", 1'b0, servo);
    pulse_srv;
    chk_bit("servo_power_en", 1'b0, servo);
    apb(1'b1, spsi_pkg::ADDR_CTRL, 32'h1);
    pulse_srv;
    chk_bit("servo_power_en", 1'b1, servo);
    apb(1'b1, spsi_pkg::ADDR_CTRL, 32'h0);
    cyc(8);
    chk_bit("servo_power_en", 1'b0, servo);
    fence <= 1'b1;
    test_end("fence");
    pulse_srv;
    pstop_ok <= 1'b0;
    cyc(8);
    chk_bit("servo_power_en", 1'b0, servo);
    pstop_ok <= 1'b1;
    test_end("pstop");
    apb(1'b1, spsi_pkg::ADDR_IRQ_STAT, 32'hFFFF_FFFF);
    split <= 1'b1;
    cyc(DISC + 12);
    chk_bit("safety_alarm", 1'b1, alarm);
    rd(spsi_pkg::ADDR_IRQ_STAT, 32'h8, "irq_stat");
    chk_bit("irq", 1'b0, irq);
    apb(1'b1, spsi_pkg::ADDR_IRQ_MASK, 32'h8);
    cyc(3);
    chk_bit("irq", 1'b1, irq);
    apb(1'b1, spsi_pkg::ADDR_IRQ_STAT, 32'h8);
    cyc(3);
    chk_bit("irq", 1'b0, irq);
    split <= 1'b0;
    cyc(4);
    apb(1'b1, spsi_pkg::ADDR_CTRL, 32'h4);
    cyc(3);
    chk_bit("safety_alarm", 1'b0, alarm);
    test_end("alarm");
    pend <= 1'b0;
    cyc(3);
    chk_bit("pendant_out", 1'b0, pend_out);
    pend <= 1'b1;
    cyc(3);
    chk_bit("pendant_out", 1'b1, pend_out);
    test_end("pendant");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      gp_in  <= rnd[7:0];
      dir_in <= rnd[11:8];
      apb(1'b1, spsi_pkg::ADDR_GP_OUT, {24'h0, rnd[23:16]});
      cyc(1);
      chk_word("gp_out", {24'h0, rnd[23:16]}, {24'h0, gp_out});
      rd(spsi_pkg::ADDR_GP_IN, {24'h0, rnd[7:0]}, "gp_in");
      rd(spsi_pkg::ADDR_DIRECT, {28'h0, rnd[11:8]}, "direct");
      rd(spsi_pkg::ADDR_GP_OUT, {24'h0, rnd[23:16]}, "gp_rd");
    end
    dir_in <= 4'h0;
    cyc(4);
    apb(1'b1, spsi_pkg::ADDR_IRQ_STAT, 32'hFFFF_FFFF);
    dir_in <= 4'hF;
    cyc(6);
    rd(spsi_pkg::ADDR_IRQ_STAT, 32'h0000_03C0, "direct_irq");
    test_end("discrete_io");
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
